// ===== dv/ers_event_router_properties.sv
/* Port checker for the event routing unit.
   Assumes it is bound to every ers_event_router instance. */
`timescale 1ns/100ps
module ers_evr_props (
    input wire        mclk,
    input wire        rst_b,
    input wire        ce,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [2:0]  pin_out_en,
    input wire [10:0] dual_user_evt,
    input wire [1:0]  sync_only_user_evt,
    input wire [2:0]  pin_event_output,
    input wire [2:0]  pin_event_output_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Routing and pins
    // ==========================================================
    chk_pin_gate: assert property (pin_event_output == (dual_user_evt[10:8] & pin_out_en))
        else $error("pin output differs from gated user event");
    chk_oe_follow: assert property (pin_event_output_oe == pin_out_en)
        else $error("pin enable not passed through");
    chk_reset_quiet: assert property ($rose(rst_b) |-> dual_user_evt == 11'h000
        && sync_only_user_evt == 2'h0 && avs_waitrequest && avs_readdata == 32'h0)
        else $error("outputs not quiet after reset");
    // ==========================================================
    // Register bus
    // ==========================================================
    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce
        |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without a request");
    chk_ce_freeze: assert property (!ce |=> $stable(avs_waitrequest) && $stable(avs_readdata))
        else $error("bus state moved while clock stopped");
    chk_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    chk_rd_upper: assert property (avs_readdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
endmodule
bind ers_event_router ers_evr_props i_ers_evr_props (.mclk(mclk), .rst_b(rst_b), .ce(ce),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_out_en(pin_out_en), .dual_user_evt(dual_user_evt),
    .sync_only_user_evt(sync_only_user_evt), .pin_event_output(pin_event_output),
    .pin_event_output_oe(pin_event_output_oe));

// ===== dv/ers_gen_model.sv
/* Event generator peripherals standing at the routing unit's far side.
   Assumes the bench supplies the wanted generator levels on a_src and s_src. */
`timescale 1ns/100ps
module ers_gen_model #(
    parameter AW = 72,
    parameter SW = 40
) (
    input  wire          mclk,
    input  wire [AW-1:0] a_src,
    input  wire [SW-1:0] s_src,
    output wire [AW-1:0] async_gen_evt,
    output reg  [SW-1:0] sync_gen_evt
);
    // Asynchronous sources move off the clock so the routing path is never helped by an edge.
    assign #7 async_gen_evt = a_src;
    initial sync_gen_evt = {SW{1'b0}};
    always @(posedge mclk) begin
        sync_gen_evt <= s_src;
    end
endmodule

// ===== dv/tb.sv
/* Self-checking bench for the event routing unit.
   Assumes the design defaults of 18 asynchronous and 20 synchronous generators. */
`timescale 1ns/100ps
module tb;
    localparam [35:0] RSV = {6'h06, 6'h09, 6'h0C, 6'h11, 6'h1D, 6'h21};
    reg         mclk, rst_b, ce, rd, wr;
    reg  [5:0]  adr;
    reg  [31:0] wd;
    reg  [3:0]  be;
    reg  [71:0] a_src;
    reg  [39:0] s_src;
    reg  [2:0]  pen;
    reg  [7:0]  q;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire [71:0] async_gen_evt;
    wire [39:0] sync_gen_evt;
    wire [10:0] dual_user_evt;
    wire [1:0]  sync_only_user_evt;
    wire [2:0]  pin_out, pin_oe;
    integer     failures, checks, i, n, k, c;
    ers_event_router i_ers_event_router (.mclk(mclk), .rst_b(rst_b), .ce(ce), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .async_gen_evt(async_gen_evt), .sync_gen_evt(sync_gen_evt), .pin_out_en(pen),
        .dual_user_evt(dual_user_evt), .sync_only_user_evt(sync_only_user_evt),
        .pin_event_output(pin_out), .pin_event_output_oe(pin_oe));
    ers_gen_model i_ers_gen_model (.mclk(mclk), .a_src(a_src), .s_src(s_src),
        .async_gen_evt(async_gen_evt), .sync_gen_evt(sync_gen_evt));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ==========================================================
    // Bus and compare tasks
    // ==========================================================
    task give_verdict;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task cmp(input [31:0] g, input [31:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("BAD %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task req(input w, input [5:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            adr <= a;
            wd <= {24'h000000, d};
            wr <= w;
            rd <= ~w;
        end
    endtask
    // The request is held until waitrequest is seen low; read data is taken at that same edge.
    task fin;
        integer t;
        begin
            t = 0;
            do begin
                @(posedge mclk);
                t = t + 1;
            end while (avs_waitrequest !== 1'b0 && t < 40);
            q = avs_readdata[7:0];
            wr <= 1'b0;
            rd <= 1'b0;
            if (t >= 40) begin
                failures = failures + 1;
                $display("BAD %0t bus timeout", $time);
                give_verdict;
            end
        end
    endtask
    task acc(input w, input [5:0] a, input [7:0] d);
        begin
            req(w, a, d);
            fin;
        end
    endtask
    task rdc(input [5:0] a, input [7:0] e);
        begin
            acc(1'b0, a, 8'h00);
            cmp({24'h0, q}, {24'h0, e});
        end
    endtask
    task drive_a(input [71:0] v, input integer u, input e);
        begin
            @(posedge mclk);
            a_src <= v;
            @(posedge mclk);
            #1;
            cmp({31'h0, dual_user_evt[u]}, {31'h0, e});
        end
    endtask
    task drive_s(input [39:0] v, input integer m, input e);
        begin
            @(posedge mclk);
            s_src <= v;
            repeat (2) @(posedge mclk);
            #1;
            cmp({31'h0, sync_only_user_evt[m]}, {31'h0, e});
            cmp({31'h0, dual_user_evt[4+m]}, {31'h0, e});
        end
    endtask
    // Counts the cycles in which user u differs from its level before the strobe.
    task pulses(input integer u, input [5:0] a, input [7:0] d);
        reg b;
        begin
            b = dual_user_evt[u];
            acc(1'b1, a, d);
            c = 0;
            repeat (6) begin
                #1;
                if (dual_user_evt[u] !== b) c = c + 1;
                @(posedge mclk);
            end
        end
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        failures = failures + 1;
        $display("BAD %0t run timeout", $time);
        give_verdict;
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        rst_b = 1'b0; ce = 1'b1; rd = 1'b0; wr = 1'b0; adr = 6'h00; wd = 32'h0; be = 4'hF;
        a_src = 72'h0; s_src = 40'h0; pen = 3'h0; failures = 0; checks = 0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        for (i = 0; i < 36; i = i + 1) rdc(i[5:0], 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            acc(1'b1, RSV[i*6 +: 6], 8'hFF);
            rdc(RSV[i*6 +: 6], 8'h00);
        end
        for (n = 0; n < 4; n = n + 1) begin
            for (k = 1; k < 19; k = k + 17) begin
                acc(1'b1, 6'h02 + n[5:0], k[7:0]);
                acc(1'b1, 6'h12 + n[5:0], 8'h03 + n[7:0]);
                rdc(6'h02 + n[5:0], k[7:0]);
                rdc(6'h12 + n[5:0], 8'h03 + n[7:0]);
                drive_a(~(72'h1 << (n * 18 + k - 1)), n, 1'b0);
                drive_a(72'h1 << (n * 18 + k - 1), n, 1'b1);
            end
        end
        acc(1'b1, 6'h02, 8'h00);
        drive_a({72{1'b1}}, 0, 1'b0);
        for (n = 0; n < 2; n = n + 1) begin
            acc(1'b1, 6'h0A + n[5:0], 8'h14);
            acc(1'b1, 6'h22 + n[5:0], 8'h01 + n[7:0]);
            acc(1'b1, 6'h16 + n[5:0], 8'h01 + n[7:0]);
            drive_s(40'h1 << (n * 20 + 19), n, 1'b1);
            drive_s(~(40'h1 << (n * 20 + 19)), n, 1'b0);
        end
        acc(1'b1, 6'h02, 8'h01);
        for (i = 8; i < 11; i = i + 1) acc(1'b1, 6'h12 + i[5:0], 8'h03);
        drive_a(72'h1, 8, 1'b1);
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge mclk);
            pen <= i[2:0];
            @(posedge mclk);
            #1;
            cmp({29'h0, pin_out}, {29'h0, i[2:0]});
            cmp({29'h0, pin_oe}, {29'h0, i[2:0]});
        end
        // A write without its low byte lane enabled must leave the pick untouched.
        @(posedge mclk);
        be <= 4'h0;
        acc(1'b1, 6'h1C, 8'h05);
        be <= 4'hF;
        rdc(6'h1C, 8'h03);
        for (i = 0; i < 6; i = i + 1) begin
            pulses(i, (i < 4) ? 6'h00 : 6'h01, 8'h01 << ((i < 4) ? i : i - 4));
            cmp(c, 1);
        end
        // Async channel 0 and sync channel 0 stand high, the others low.
        rdc(6'h24, 8'h11);
        @(posedge mclk);
        ce <= 1'b0;
        drive_a(72'h0, 0, 1'b0);
        drive_a(72'h1, 0, 1'b1);
        req(1'b1, 6'h00, 8'h01);
        c = 0;
        repeat (6) begin
            @(posedge mclk);
            #1;
            if (dual_user_evt[0] !== 1'b1) c = c + 1;
        end
        cmp(c, 0);
        cmp({31'h0, avs_waitrequest}, 32'h1);
        @(posedge mclk);
        ce <= 1'b1;
        fin;
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        cmp({21'h0, dual_user_evt}, 32'h0);
        rdc(6'h1C, 8'h00);
        give_verdict;
    end
endmodule

// ===== rtl/ers_defines.vh
/*
 * Register indices, field layouts, reset values and selector codes for the
 * event routing unit.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef ERS_DEFINES_VH
`define ERS_DEFINES_VH

// ====================================================================
// Register indices (byte address is four times the index)
// ====================================================================
`define ERS_IDX_ASYNC_STROBE      6'h00
`define ERS_IDX_SYNC_STROBE       6'h01
`define ERS_IDX_ASYNC_CH0         6'h02
`define ERS_IDX_ASYNC_CH3         6'h05
`define ERS_IDX_SYNC_CH0          6'h0A
`define ERS_IDX_SYNC_CH1          6'h0B
`define ERS_IDX_DUAL_USER0        6'h12
`define ERS_IDX_DUAL_USER10       6'h1C
`define ERS_IDX_SYNC_USER0        6'h22
`define ERS_IDX_SYNC_USER1        6'h23
`define ERS_IDX_CHAN_STATE        6'h24

// ====================================================================
// Counts, widths and reset values
// ====================================================================
`define ERS_NUM_ASYNC_CH          4
`define ERS_NUM_SYNC_CH           2
`define ERS_NUM_DUAL_USER         11
`define ERS_NUM_SYNC_USER         2
`define ERS_NUM_PIN_OUT           3
`define ERS_FIRST_PIN_USER        8
`define ERS_ASYNC_GEN_N           18
`define ERS_SYNC_GEN_N            20
`define ERS_REG_RESET             8'h00

// ====================================================================
// Selector codes
// ====================================================================
`define ERS_SEL_OFF               8'h00
`define ERS_USEL_SYNC0            8'h01
`define ERS_USEL_ASYNC0           8'h03

// ====================================================================
// Channel state register layout
// ====================================================================
`define ERS_STATE_ASYNC_LSB       0
`define ERS_STATE_SYNC_LSB        4

`endif

// ===== rtl/ers_event_router.v
/*
 * Event routing unit: channel source selection, software strobes, per-user
 * channel multiplexers, pin event outputs and the Avalon-MM register slave.
 * Assumes generators and users on chip; the pin multiplexer supplies the
 * pin output enables from its own register on mclk.
 */
// The Avalon-MM slave port was left to the implementer.
//
// Contract
// - Events travel synchronously or asynchronously according to channel type.
// - Pulses and level events pass through unchanged in shape.
// - Four asynchronous and two synchronous channels, all selectable by users.
// - Three pin outputs, driven asynchronously, fed by user selectors 8, 9, 10.
// - A pin output reaches its pin only when its enable bit is one.
// - Each user has a dedicated multiplexer forwarding exactly one channel.
// - Dual users take both kinds; some users take synchronous only.
// - Dual users use dual pick registers; sync-only users use sync pick registers.
// - After reset every user multiplexer selects nothing.
// - Channels accept only generators of their own kind.
// - Each channel forwards one generator chosen by its source register.
// - After reset no channel connects to any generator.
// - A software event inverts the channel value for one clock cycle.
// - Writing one to strobe bit k fires a software event on channel k.
// - Users see software events exactly like generator events.
// - Register accesses and software events run on the peripheral clock.
// - Configured routing works in sleep with no clock on the paths.
// - Software strobes do nothing while the peripheral clock is stopped.
// - Debug mode does not change routing behaviour.
// - Asynchronous events are synchronised by users; others pick sync only.
// - Dual pick codes: 0 off, 1-2 sync channels, 3-6 async channels.
// - Sync pick codes: 0 off, 1 and 2 for the sync channels.
// - Source code 0x00 disconnects the channel from every generator.
`timescale 1ns/100ps
`include "ers_defines.vh"

module ers_event_router #(
    parameter ASYNC_GEN_N = `ERS_ASYNC_GEN_N,
    parameter SYNC_GEN_N  = `ERS_SYNC_GEN_N
) (
    input  wire                                 mclk,
    input  wire                                 rst_b,
    input  wire                                 ce,
    input  wire [5:0]                           avs_address,
    input  wire                                 avs_read,
    input  wire                                 avs_write,
    input  wire [31:0]                          avs_writedata,
    input  wire [3:0]                           avs_byteenable,
    output reg  [31:0]                          avs_readdata,
    output reg                                  avs_waitrequest,
    input  wire [`ERS_NUM_ASYNC_CH*ASYNC_GEN_N-1:0] async_gen_evt,
    input  wire [`ERS_NUM_SYNC_CH*SYNC_GEN_N-1:0]   sync_gen_evt,
    input  wire [`ERS_NUM_PIN_OUT-1:0]          pin_out_en,
    output wire [`ERS_NUM_DUAL_USER-1:0]        dual_user_evt,
    output wire [`ERS_NUM_SYNC_USER-1:0]        sync_only_user_evt,
    output wire [`ERS_NUM_PIN_OUT-1:0]          pin_event_output,
    output wire [`ERS_NUM_PIN_OUT-1:0]          pin_event_output_oe
);

    localparam NA = `ERS_NUM_ASYNC_CH;
    localparam NS = `ERS_NUM_SYNC_CH;
    localparam NU = `ERS_NUM_DUAL_USER;
    localparam NY = `ERS_NUM_SYNC_USER;
    localparam NP = `ERS_NUM_PIN_OUT;

    // ================================================================
    // Configuration storage
    // ================================================================
    reg  [7:0]        async_src_r  [0:NA-1];
    reg  [7:0]        sync_src_r   [0:NS-1];
    reg  [7:0]        dual_pick_r  [0:NU-1];
    reg  [7:0]        sync_pick_r  [0:NY-1];
    reg  [NA-1:0]     async_stb_r;
    reg  [NS-1:0]     sync_stb_r;
    reg  [NA-1:0]     async_meta_r;
    reg  [NA-1:0]     async_seen_r;
    reg               wait_r;

    wire [NA-1:0]     async_raw;
    wire [NS-1:0]     sync_raw;
    wire [NA-1:0]     async_ch;
    wire [NS-1:0]     sync_ch;
    wire [NS+NA-1:0]  dual_src;
    wire              wr_go;
    wire              rd_go;
    wire [5:0]        idx;
    reg  [7:0]        rd_val;

    integer k;
    integer j;

    assign idx   = avs_address;
    // Writes land at the edge where the master sees waitrequest low.
    assign wr_go = ce & avs_write & ~wait_r & avs_byteenable[0];
    // Read data is captured one edge earlier so it stands when taken.
    assign rd_go = ce & avs_read & wait_r;

    // ================================================================
    // Channel source selection
    // ================================================================
    genvar g;
    generate
        for (g = 0; g < NA; g = g + 1) begin : g_async_ch
            // Only asynchronous generators are wired to these selectors.
            ers_sel_mux #(
                .N   (ASYNC_GEN_N)
            ) u_src (
                .sel (async_src_r[g]),
                .src (async_gen_evt[g*ASYNC_GEN_N +: ASYNC_GEN_N]),
                .evt (async_raw[g])
            );
            // The strobe flips the current level for exactly one cycle.
            assign async_ch[g] = async_raw[g] ^ async_stb_r[g];
        end
        for (g = 0; g < NS; g = g + 1) begin : g_sync_ch
            ers_sel_mux #(
                .N   (SYNC_GEN_N)
            ) u_src (
                .sel (sync_src_r[g]),
                .src (sync_gen_evt[g*SYNC_GEN_N +: SYNC_GEN_N]),
                .evt (sync_raw[g])
            );
            assign sync_ch[g] = sync_raw[g] ^ sync_stb_r[g];
        end
    endgenerate

    // ================================================================
    // User multiplexers
    // ================================================================
    // Code order: sync channels first, then async channels.
    assign dual_src = {async_ch, sync_ch};

    generate
        for (g = 0; g < NU; g = g + 1) begin : g_dual_user
            // Combinational path, so routing keeps working with mclk stopped
            // and shapes pulses and levels alike.
            ers_sel_mux #(
                .N   (NS + NA)
            ) u_pick (
                .sel (dual_pick_r[g]),
                .src (dual_src),
                .evt (dual_user_evt[g])
            );
        end
        for (g = 0; g < NY; g = g + 1) begin : g_sync_user
            // Async channels are not even wired here, so these users never
            // see an unsynchronised event.
            ers_sel_mux #(
                .N   (NS)
            ) u_pick (
                .sel (sync_pick_r[g]),
                .src (sync_ch),
                .evt (sync_only_user_evt[g])
            );
        end
        for (g = 0; g < NP; g = g + 1) begin : g_pin
            assign pin_event_output[g] =
                dual_user_evt[`ERS_FIRST_PIN_USER + g] & pin_out_en[g];
            assign pin_event_output_oe[g] = pin_out_en[g];
        end
    endgenerate

    // ================================================================
    // Channel state sampling for readback
    // ================================================================
    // Async channel levels are foreign to mclk and pass two flops first.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            async_meta_r <= {NA{1'b0}};
            async_seen_r <= {NA{1'b0}};
        end else if (ce) begin
            async_meta_r <= async_ch;
            async_seen_r <= async_meta_r;
        end
    end

    // ================================================================
    // Register write path and software strobes
    // ================================================================
    // No debug input exists, so debug mode cannot alter anything here
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (k = 0; k < NA; k = k + 1) begin
                async_src_r[k] <= `ERS_REG_RESET;
            end
            for (k = 0; k < NS; k = k + 1) begin
                sync_src_r[k] <= `ERS_REG_RESET;
            end
            for (k = 0; k < NU; k = k + 1) begin
                dual_pick_r[k] <= `ERS_REG_RESET;
            end
            for (k = 0; k < NY; k = k + 1) begin
                sync_pick_r[k] <= `ERS_REG_RESET;
            end
            async_stb_r <= {NA{1'b0}};
            sync_stb_r  <= {NS{1'b0}};
        end else if (ce) begin
            // Strobes last one cycle; with ce low they cannot fire at all.
            async_stb_r <= {NA{1'b0}};
            sync_stb_r  <= {NS{1'b0}};
            if (wr_go) begin
                if (idx == `ERS_IDX_ASYNC_STROBE) begin
                    async_stb_r <= avs_writedata[NA-1:0];
                end
                if (idx == `ERS_IDX_SYNC_STROBE) begin
                    sync_stb_r <= avs_writedata[NS-1:0];
                end
                for (k = 0; k < NA; k = k + 1) begin
                    if (idx == `ERS_IDX_ASYNC_CH0 + k[5:0]) begin
                        async_src_r[k] <= avs_writedata[7:0];
                    end
                end
                for (k = 0; k < NS; k = k + 1) begin
                    if (idx == `ERS_IDX_SYNC_CH0 + k[5:0]) begin
                        sync_src_r[k] <= avs_writedata[7:0];
                    end
                end
                for (k = 0; k < NU; k = k + 1) begin
                    if (idx == `ERS_IDX_DUAL_USER0 + k[5:0]) begin
                        dual_pick_r[k] <= avs_writedata[7:0];
                    end
                end
                for (k = 0; k < NY; k = k + 1) begin
                    if (idx == `ERS_IDX_SYNC_USER0 + k[5:0]) begin
                        sync_pick_r[k] <= avs_writedata[7:0];
                    end
                end
            end
        end
    end

    // ================================================================
    // Register read decode
    // ================================================================
    // Strobe registers read zero: the pulse is gone before a read sees it.
    always @* begin
        rd_val = 8'h00;
        for (j = 0; j < NA; j = j + 1) begin
            if (idx == `ERS_IDX_ASYNC_CH0 + j[5:0]) begin
                rd_val = async_src_r[j];
            end
        end
        for (j = 0; j < NS; j = j + 1) begin
            if (idx == `ERS_IDX_SYNC_CH0 + j[5:0]) begin
                rd_val = sync_src_r[j];
            end
        end
        for (j = 0; j < NU; j = j + 1) begin
            if (idx == `ERS_IDX_DUAL_USER0 + j[5:0]) begin
                rd_val = dual_pick_r[j];
            end
        end
        for (j = 0; j < NY; j = j + 1) begin
            if (idx == `ERS_IDX_SYNC_USER0 + j[5:0]) begin
                rd_val = sync_pick_r[j];
            end
        end
        if (idx == `ERS_IDX_CHAN_STATE) begin
            rd_val = {2'b00, sync_raw, async_seen_r};
        end
    end

    // ================================================================
    // Avalon-MM handshake
    // ================================================================
    // Every access costs one wait cycle; the fixed cost keeps the slave
    // simple and the read data registered.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r          <= 1'b1;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (ce) begin
            if (wait_r && (avs_read || avs_write)) begin
                wait_r          <= 1'b0;
                avs_waitrequest <= 1'b0;
            end else begin
                wait_r          <= 1'b1;
                avs_waitrequest <= 1'b1;
            end
            if (rd_go) begin
                avs_readdata <= {24'h00_0000, rd_val};
            end
        end
    end

endmodule

// ===== rtl/ers_sel_mux.v
/*
 * One-of-N selector used for channel sources and user multiplexers.
 * Code 0 and any code above N give a constant low; code k forwards src[k-1].
 * Assumes a static select value; the path holds no storage and needs no clock.
 */
`timescale 1ns/100ps

module ers_sel_mux #(
    parameter N = 4
) (
    input  wire [7:0]   sel,
    input  wire [N-1:0] src,
    output reg          evt
);

    integer i;

    always @* begin
        evt = 1'b0;
        for (i = 0; i < N; i = i + 1) begin
            if (sel == i[7:0] + 8'h01) begin
                evt = src[i];
            end
        end
    end

endmodule
